// >>> sim/irq_cpu_model.sv
// Purpose: external pins and processor side that accepts interrupts
// Assumes: pins change just after a rising edge
// Notes:   accepts forwarded requests LAT+1 cycles after they show with ack_en high
`timescale 1ns/1ps
module irq_cpu_model
  import irq_timer_pkg::*;
#(
  parameter int unsigned LAT = 2
) (
  input  wire logic            hclk,
  input  wire logic            ack_en,
  input  wire logic [NSRC-1:0] cpu_irq_req,
  output logic      [NSRC-1:0] cpu_irq_ack,
  output logic                 pin_a,
  output logic                 pin_b
);
  int unsigned cnt_q = 0;

  initial begin
    cpu_irq_ack = '0;
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  task automatic set_pins(input logic a, input logic b);
    @(posedge hclk);
    pin_a <= a;
    pin_b <= b;
  endtask

  // one-cycle accept pulse, never twice in a row
  always @(posedge hclk) begin
    if (ack_en && cpu_irq_req != '0 && cpu_irq_ack == '0) cnt_q <= cnt_q + 1;
    else cnt_q <= 0;
    cpu_irq_ack <= (cnt_q == LAT) ? cpu_irq_req : '0;
  end
endmodule // irq_cpu_model

// >>> sim/tb_interrupt_timer_control_regs.sv
// Purpose: self-checking bench for the interrupt and timer registers
// Assumes: single AHB-Lite slave, hready tied to hreadyout
// Notes:   base tick lengthened to 200 cycles from the default 50
`timescale 1ns/1ps
module tb_interrupt_timer_control_regs;
  import irq_timer_pkg::*;
  localparam int unsigned DIV = 200;
  typedef struct {
    logic        w;
    logic [5:0]  idx;
    logic [31:0] d;
    logic [31:0] e;
  } row_s;
  logic            hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic            ce_pin, ser_ev, frq_ev, irq, pa, pb, ack_en;
  logic [31:0]     haddr, hwdata, hrdata, rd;
  logic [1:0]      htrans;
  logic [2:0]      hsize;
  logic [NSRC-1:0] ack, req;
  logic [3:0]      stk;
  int              errors = 0, n_tests = 0, cyc = 0, i;
  row_s rows [12] = '{
    '{0, IDX_STACK_PTR, 0, 7}, '{0, IDX_TMR_MODE, 0, 0},
    '{0, IDX_TMR_CARRY, 0, 0}, '{0, IDX_EDGE_SEL, 0, 0},
    '{0, IDX_PERMIT_HI, 0, 0}, '{0, IDX_PEND_HI, 0, 0},
    '{1, IDX_STACK_PTR, 32'hA, 32'hA}, '{1, IDX_TMR_MODE, 32'h3, 32'h3},
    '{1, IDX_EDGE_SEL, 32'h2, 32'h2}, '{1, IDX_PERMIT_LO, 32'h1, 32'h1},
    '{1, IDX_CE_LEVEL, 32'h0, 32'h1}, '{1, 6'h02, 32'h5, 32'h0}};

  interrupt_timer_control_regs #(.TICK_DIV(DIV)) interrupt_timer_control_regs_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_irq_pin_a(pa), .ext_irq_pin_b(pb), .ce_pin(ce_pin),
    .serial_one_event(ser_ev), .freq_counter_event(frq_ev),
    .cpu_irq_ack(ack), .cpu_irq_req(req), .stack_pointer(stk), .irq(irq));
  irq_cpu_model irq_cpu_model_inst (.hclk(hclk), .ack_en(ack_en),
    .cpu_irq_req(req), .cpu_irq_ack(ack), .pin_a(pa), .pin_b(pb));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic tally_and_finish;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      tally_and_finish;
    end
  end

  task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, idx, 2'b00};
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic rdchk(input logic [5:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk(rd, e);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = '0;
    ce_pin = 1'b1;
    ser_ev = 1'b0;
    frq_ev = 1'b0;
    ack_en = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk({28'h0, stk}, 32'h7);
    foreach (rows[k]) begin
      if (rows[k].w) bus(1'b1, rows[k].idx, rows[k].d);
      rdchk(rows[k].idx, rows[k].e);
    end
    chk({28'h0, stk}, 32'hA);
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, hreadyout}, 32'h1);
    bus(1'b1, IDX_TMR_MODE, 32'h0);
    settle(DIV + 10);
    rdchk(IDX_TMR_CARRY, 32'h1);
    rdchk(IDX_TMR_CARRY, 32'h0);
    bus(1'b1, IDX_TMR_MODE, 32'hF);
    rdchk(IDX_PEND_HI, 32'h4);
    irq_cpu_model_inst.set_pins(1'b1, 1'b1);
    settle(3);
    rdchk(IDX_PIN_LEVEL, 32'h3);
    rdchk(IDX_PEND_HI, 32'h5);
    irq_cpu_model_inst.set_pins(1'b0, 1'b0);
    settle(3);
    rdchk(IDX_PEND_HI, 32'h7);
    chk({27'h0, req}, 32'h0);
    @(posedge hclk);
    ser_ev <= 1'b1;
    frq_ev <= 1'b1;
    @(posedge hclk);
    ser_ev <= 1'b0;
    frq_ev <= 1'b0;
    rdchk(IDX_PEND_HI, 32'hF);
    rdchk(IDX_PEND_LO, 32'h1);
    bus(1'b1, IDX_PERMIT_HI, 32'hD);
    settle(1);
    chk({27'h0, req}, 32'h1D);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, IDX_EVT_ENABLE, 32'h1);
    settle(1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, IDX_EVT_CLEAR, 32'h1F);
    settle(1);
    chk({31'h0, irq}, 32'h0);
    rdchk(IDX_EVT_STATUS, 32'h0);
    ack_en <= 1'b1;
    for (i = 0; i < 50 && req !== '0; i++) settle(1);
    chk({27'h0, req}, 32'h0);
    rdchk(IDX_PEND_HI, 32'h2);
    rdchk(IDX_PEND_LO, 32'h0);
    // reset again in mid-run
    hresetn <= 1'b0;
    settle(1);
    chk({28'h0, stk}, 32'h7);
    chk({27'h0, req}, 32'h0);
    chk(hrdata, 32'h0);
    chk({31'h0, hreadyout}, 32'h1);
    @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(IDX_PEND_HI, 32'h0);
    rdchk(IDX_TMR_MODE, 32'h0);
    rdchk(IDX_PERMIT_HI, 32'h0);
    tally_and_finish;
  end
endmodule // tb_interrupt_timer_control_regs

// >>> verilog/interrupt_timer_control_regs.sv
// Purpose: interval timer, edge-triggered pin interrupts, permit/pending
//          bits and level sensing, reached over an AHB-Lite slave port
// Assumes: all inputs synchronous to hclk; event inputs are 1-cycle pulses
// Notes:   zero wait states; reads return data registered at the end of the address phase
`timescale 1ns/1ps
module interrupt_timer_control_regs
  import irq_timer_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic      [31:0]     hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  input  wire logic            ext_irq_pin_a,
  input  wire logic            ext_irq_pin_b,
  input  wire logic            ce_pin,
  input  wire logic            serial_one_event,
  input  wire logic            freq_counter_event,
  input  wire logic [NSRC-1:0] cpu_irq_ack,
  output logic      [NSRC-1:0] cpu_irq_req,
  output logic      [3:0]      stack_pointer,
  output logic                 irq
);

  if (TICK_DIV < 1) begin : g_bad_div
    $error("TICK_DIV must be at least 1");
  end

  if (TICK_DIV > 65536) begin : g_big_div
    $error("TICK_DIV must fit the 16-bit tick counter");
  end

  logic [15:0]     tick_cnt_q, tick_cnt_d;
  logic [IVL_W-1:0] ivl_cnt_q, ivl_cnt_d, ivl_lim;
  logic [3:0]      stk_q, stk_d, mode_q, mode_d, rdata_q, rdata_d;
  logic            carry_q, carry_d;
  logic [1:0]      edge_q, edge_d, pin_prev_q, pin_prev_d;
  logic            prev_ok_q, prev_ok_d;
  logic [NSRC-1:0] permit_q, permit_d, pend_q, pend_d;
  logic [NSRC-1:0] evt_st_q, evt_st_d, evt_en_q, evt_en_d, src_evt;
  ahb_req_s        req_q, req_d;
  logic            wr_ph_q, wr_ph_d;
  logic            base_tick, expire, addr_ok, acc, rd_acc;
  logic            rise_a, fall_a, rise_b, fall_b;
  logic [5:0]      a_idx;
  logic [3:0]      wd;

  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign hrdata      = {28'h0000000, rdata_q};
  assign stack_pointer = stk_q;
  assign cpu_irq_req = pend_q & permit_q;
  assign irq         = |(evt_st_q & evt_en_q);

  // address phase decode
  assign a_idx   = haddr[7:2];
  assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
  assign acc     = hsel && hready && htrans[1] && addr_ok;
  assign rd_acc  = acc && !hwrite;
  assign wd      = hwdata[3:0];

  // base tick and interval expiry
  assign base_tick = (tick_cnt_q == 16'(TICK_DIV - 1));
  assign ivl_lim   = (15'h0001 << mode_q) - 15'h0001;
  assign expire    = base_tick && (ivl_cnt_q == ivl_lim);

  // pin edges, polarity chosen per pin
  assign rise_a = prev_ok_q && !pin_prev_q[0] && ext_irq_pin_a;
  assign fall_a = prev_ok_q && pin_prev_q[0] && !ext_irq_pin_a;
  assign rise_b = prev_ok_q && !pin_prev_q[1] && ext_irq_pin_b;
  assign fall_b = prev_ok_q && pin_prev_q[1] && !ext_irq_pin_b;

  always_comb begin
    src_evt             = '0;
    src_evt[SRC_PIN_A]  = edge_q[0] ? fall_a : rise_a;
    src_evt[SRC_PIN_B]  = edge_q[1] ? fall_b : rise_b;
    src_evt[SRC_TIMER]  = expire;
    src_evt[SRC_SERIAL] = serial_one_event;
    src_evt[SRC_FREQ]   = freq_counter_event;
  end

  always_comb begin
    tick_cnt_d = base_tick ? 16'h0000 : tick_cnt_q + 16'h0001;
    ivl_cnt_d  = ivl_cnt_q;
    if (expire) begin
      ivl_cnt_d = '0;
    end else if (base_tick) begin
      ivl_cnt_d = ivl_cnt_q + 15'h0001;
    end
    stk_d      = stk_q;
    mode_d     = mode_q;
    carry_d    = carry_q;
    edge_d     = edge_q;
    permit_d   = permit_q;
    pend_d     = pend_q;
    evt_st_d   = evt_st_q;
    evt_en_d   = evt_en_q;
    pin_prev_d = {ext_irq_pin_b, ext_irq_pin_a};
    prev_ok_d  = 1'b1;
    req_d      = '{wr: hwrite, idx: a_idx};
    wr_ph_d    = acc && hwrite;
    rdata_d    = rdata_q;

    // data phase of a write
    if (wr_ph_q) begin
      case (req_q.idx)
        IDX_STACK_PTR:  stk_d = wd;
        IDX_TMR_MODE: begin
          mode_d     = wd;
          ivl_cnt_d  = '0;
          tick_cnt_d = 16'h0000;
        end
        IDX_EDGE_SEL:   edge_d = wd[1:0];
        IDX_PERMIT_LO:  permit_d[SRC_FREQ] = wd[0];
        IDX_PERMIT_HI:  permit_d[3:0] = wd;
        IDX_PEND_LO:    pend_d[SRC_FREQ] = wd[0];
        IDX_PEND_HI:    pend_d[3:0] = wd;
        IDX_EVT_ENABLE: evt_en_d = hwdata[NSRC-1:0];
        IDX_EVT_CLEAR:  evt_st_d = evt_st_q & ~hwdata[NSRC-1:0];
        default: begin
        end
      endcase
    end

    // address phase of a read: capture data, apply read side effects
    if (rd_acc) begin
      case (a_idx)
        IDX_STACK_PTR:  rdata_d = stk_q;
        IDX_CE_LEVEL:   rdata_d = {3'h0, ce_pin};
        IDX_TMR_MODE:   rdata_d = mode_q;
        IDX_PIN_LEVEL:  rdata_d = {2'h0, ext_irq_pin_b, ext_irq_pin_a};
        IDX_TMR_CARRY: begin
          rdata_d = {3'h0, carry_q};
          carry_d = 1'b0;
        end
        IDX_EDGE_SEL:   rdata_d = {2'h0, edge_q};
        IDX_PERMIT_LO:  rdata_d = {3'h0, permit_q[SRC_FREQ]};
        IDX_PERMIT_HI:  rdata_d = permit_q[3:0];
        IDX_PEND_LO:    rdata_d = {3'h0, pend_q[SRC_FREQ]};
        IDX_PEND_HI:    rdata_d = pend_q[3:0];
        IDX_EVT_STATUS: rdata_d = evt_st_q[3:0];
        IDX_EVT_ENABLE: rdata_d = evt_en_q[3:0];
        default:        rdata_d = 4'h0;
      endcase
    end

    // acceptance clears, then new requests win over any clear
    pend_d   = (pend_d & ~cpu_irq_ack) | src_evt;
    evt_st_d = evt_st_d | src_evt;
    if (expire) begin
      carry_d = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 16'h0000;
      ivl_cnt_q  <= '0;
      stk_q      <= RST_STACK_PTR;
      mode_q     <= RST_TMR_MODE;
      carry_q    <= 1'b0;
      edge_q     <= RST_EDGE_SEL;
      permit_q   <= RST_PERMIT;
      pend_q     <= RST_PENDING;
      evt_st_q   <= RST_EVT;
      evt_en_q   <= RST_EVT;
      pin_prev_q <= 2'h0;
      prev_ok_q  <= 1'b0;
      req_q      <= '0;
      wr_ph_q    <= 1'b0;
      rdata_q    <= 4'h0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      ivl_cnt_q  <= ivl_cnt_d;
      stk_q      <= stk_d;
      mode_q     <= mode_d;
      carry_q    <= carry_d;
      edge_q     <= edge_d;
      permit_q   <= permit_d;
      pend_q     <= pend_d;
      evt_st_q   <= evt_st_d;
      evt_en_q   <= evt_en_d;
      pin_prev_q <= pin_prev_d;
      prev_ok_q  <= prev_ok_d;
      req_q      <= req_d;
      wr_ph_q    <= wr_ph_d;
      rdata_q    <= rdata_d;
    end
  end

  // checks
  timer_expiry_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    expire |=> pend_q[SRC_TIMER] && carry_q)
    else $error("timer expiry did not set pending and carry");

  mode_restart_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ph_q && (req_q.idx == IDX_TMR_MODE)
    |=> (ivl_cnt_q == '0) && (tick_cnt_q == 16'h0000)
    && (mode_q == $past(hwdata[3:0])))
    else $error("mode write did not restart the interval");

  ivl_bound_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ivl_cnt_q <= ivl_lim)
    else $error("interval count passed its limit");

  carry_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_acc && (a_idx == IDX_TMR_CARRY) && !expire |=> !carry_q)
    else $error("carry flag not cleared by read");

  carry_read_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_acc && (a_idx == IDX_TMR_CARRY)
    |=> hrdata == {31'h00000000, $past(carry_q)})
    else $error("carry read returned wrong value");

  rise_pin_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !edge_q[0] && rise_a |=> pend_q[SRC_PIN_A])
    else $error("rising edge on pin a not requested");

  fall_pin_b_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    edge_q[1] && rise_b && !fall_b && !$past(pend_q[SRC_PIN_B])
    && (cpu_irq_ack[SRC_PIN_B] || !pend_q[SRC_PIN_B]) && !wr_ph_q
    |=> !pend_q[SRC_PIN_B])
    else $error("rising edge requested pin b in falling mode");

  fall_pin_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    edge_q[1] && fall_b |=> pend_q[SRC_PIN_B])
    else $error("falling edge on pin b not requested");

  permit_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ph_q && (req_q.idx == IDX_PERMIT_HI)
    |=> permit_q[3:0] == $past(hwdata[3:0]))
    else $error("permit write not stored");

  accept_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cpu_irq_ack[SRC_SERIAL] && !serial_one_event && !wr_ph_q
    |=> !pend_q[SRC_SERIAL] && !cpu_irq_req[SRC_SERIAL])
    else $error("accepted request not cleared");

  pend_set_wins_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (|src_evt) |=> (pend_q & $past(src_evt)) == $past(src_evt))
    else $error("new request lost against a clear");

  level_read_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_acc && (a_idx == IDX_PIN_LEVEL)
    |=> hrdata[1:0] == $past({ext_irq_pin_b, ext_irq_pin_a}))
    else $error("pin level read wrong");

  forward_gate_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(permit_q[SRC_TIMER]) && $past(pend_q[SRC_TIMER])
    && pend_q[SRC_TIMER] |-> cpu_irq_req[SRC_TIMER] ##1
    (!permit_q[SRC_TIMER] || !pend_q[SRC_TIMER] || cpu_irq_req[SRC_TIMER]))
    else $error("permitted pending request not forwarded");

  stack_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ph_q && (req_q.idx == IDX_STACK_PTR)
    |=> stack_pointer == $past(hwdata[3:0]))
    else $error("stack pointer write not stored");

  evt_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ph_q && (req_q.idx == IDX_EVT_CLEAR)
    |=> (evt_st_q & $past(hwdata[NSRC-1:0] & ~src_evt)) == '0)
    else $error("event status not cleared by write");

  timer_fire_c: cover property (@(posedge hclk) disable iff (!hresetn)
    expire ##1 cpu_irq_req[SRC_TIMER]);
  pin_edge_c: cover property (@(posedge hclk) disable iff (!hresetn)
    fall_a && edge_q[0]);
  irq_out_c: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(irq));
  ack_clear_c: cover property (@(posedge hclk) disable iff (!hresetn)
    cpu_irq_ack[SRC_SERIAL] ##1 !pend_q[SRC_SERIAL]);
  carry_read_c: cover property (@(posedge hclk) disable iff (!hresetn)
    rd_acc && (a_idx == IDX_TMR_CARRY) && carry_q);

endmodule // interrupt_timer_control_regs

// >>> verilog/irq_timer_pkg.sv
// Purpose: constants and types for the interrupt and timer control registers
// Assumes: register indices are word indices; byte address = 4 * index
// Notes:   event status, enable and clear indices sit in an unused gap
package irq_timer_pkg;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned NSRC  = 5;

  // register indices
  localparam logic [5:0] IDX_STACK_PTR  = 6'h01;
  localparam logic [5:0] IDX_CE_LEVEL   = 6'h07;
  localparam logic [5:0] IDX_TMR_MODE   = 6'h09;
  localparam logic [5:0] IDX_PIN_LEVEL  = 6'h0F;
  localparam logic [5:0] IDX_TMR_CARRY  = 6'h17;
  localparam logic [5:0] IDX_EDGE_SEL   = 6'h1F;
  localparam logic [5:0] IDX_PERMIT_LO  = 6'h2E;
  localparam logic [5:0] IDX_PERMIT_HI  = 6'h2F;
  localparam logic [5:0] IDX_EVT_STATUS = 6'h3A;
  localparam logic [5:0] IDX_EVT_ENABLE = 6'h3B;
  localparam logic [5:0] IDX_EVT_CLEAR  = 6'h3C;
  localparam logic [5:0] IDX_PEND_LO    = 6'h3E;
  localparam logic [5:0] IDX_PEND_HI    = 6'h3F;

  // values after reset
  localparam logic [3:0] RST_STACK_PTR = 4'h7;
  localparam logic [3:0] RST_TMR_MODE  = 4'h0;
  localparam logic [1:0] RST_EDGE_SEL  = 2'h0;
  localparam logic [4:0] RST_PERMIT    = 5'h00;
  localparam logic [4:0] RST_PENDING   = 5'h00;
  localparam logic [4:0] RST_EVT       = 5'h00;

  // source bit positions in the 5-bit permit/pending vectors
  localparam int unsigned SRC_PIN_A  = 0;
  localparam int unsigned SRC_PIN_B  = 1;
  localparam int unsigned SRC_TIMER  = 2;
  localparam int unsigned SRC_SERIAL = 3;
  localparam int unsigned SRC_FREQ   = 4;

  // timer base tick
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned TICK_NS     = 1000;
  localparam int unsigned TICK_CYCLES = (TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned IVL_W       = 15;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic       wr;
    logic [5:0] idx;
  } ahb_req_s;
endpackage
